// >>> hdl/plms_link_select.sv
// programmer link front end: mode entry, pulse count, serial engines
// assumes all pins are asynchronous to clk; the serial clock is sampled
`timescale 1ns/10ps
module plms_link_select
  import plms_pkg::*;
#(
  parameter int unsigned BitCycReset = BIT_CYC_RESET,
  parameter int unsigned SelIdleCyc  = SEL_IDLE_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // mode pins
  input  wire logic       modePulsePin,
  input  wire logic       modeSelectPin,
  // async serial port
  input  wire logic       asyncReceivePin,
  output logic            asyncTransmitPin,
  // clocked serial port
  input  wire logic       serialClockPin,
  input  wire logic       clockedSerialIn,
  output logic            clockedSerialOut,
  output logic            clockedSerialOutOe,
  // handshake line
  input  wire logic       handshakeIn,
  output logic            handshakeOut,
  output logic            handshakeOe,
  // status toward command processor
  output logic            progMode,
  output plms_link_t      linkMode,
  output logic            linkValid,
  output logic            rxOverrun,
  // received command bytes
  output logic            cmdValid,
  input  wire logic       cmdReady,
  output logic [7:0]      cmdData,
  // response bytes
  input  wire logic       rspValid,
  output logic            rspReady,
  input  wire logic [7:0] rspData
);
  logic [PIN_N-1:0] pinRaw;
  logic [PIN_N-1:0] pinMeta_ff;
  logic [PIN_N-1:0] pin_ff;
  logic [PIN_N-1:0] pinPrev_ff;
  plms_phase_t      phase_ff;
  plms_link_t       link_ff;
  logic [1:0]       strapCnt_ff;
  logic [3:0]       pulseCnt_ff;
  logic [CNT_W-1:0] idleCnt_ff;
  logic             pulseRise;
  logic             rxFall;
  logic             sckRise;
  logic             sckFall;
  logic             serialStart;
  logic             pushValid;
  logic [7:0]       pushData;
  logic             bufReady;
  logic             isAsync;
  logic             isClk;
  // async engine
  plms_rx_t         rxState_ff;
  logic [CNT_W-1:0] bitCyc_ff;
  logic [CNT_W-1:0] rxCnt_ff;
  logic [2:0]       rxBit_ff;
  logic [7:0]       rxSh_ff;
  logic             calDone_ff;
  logic             rxPush_ff;
  logic [9:0]       txFrame_ff;
  logic [3:0]       txLeft_ff;
  logic [CNT_W-1:0] txCnt_ff;
  // clocked engine
  logic [7:0]       csiIn_ff;
  logic [2:0]       csiBit_ff;
  logic [7:0]       csiOut_ff;
  logic             csiPush_ff;
  logic [7:0]       holdData_ff;
  logic             held_ff;
  logic             soBit_ff;
  logic             unusedHs;

  assign pinRaw = {clockedSerialIn, serialClockPin, asyncReceivePin,
                   modeSelectPin, modePulsePin};

  // two-stage synchroniser per pin
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++)
    begin : g_sync
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          pinMeta_ff[gi] <= 1'b0;
          pin_ff[gi]     <= 1'b0;
          pinPrev_ff[gi] <= 1'b0;
        end
        else
        begin
          pinMeta_ff[gi] <= pinRaw[gi];
          pin_ff[gi]     <= pinMeta_ff[gi];
          pinPrev_ff[gi] <= pin_ff[gi];
        end
      end
    end
  endgenerate

  assign pulseRise = pin_ff[PIN_PULSE] && !pinPrev_ff[PIN_PULSE];
  assign rxFall    = !pin_ff[PIN_RX] && pinPrev_ff[PIN_RX];
  assign sckRise   = pin_ff[PIN_SCK] && !pinPrev_ff[PIN_SCK];
  assign sckFall   = !pin_ff[PIN_SCK] && pinPrev_ff[PIN_SCK];
  assign serialStart = rxFall || sckRise || sckFall;
  assign isAsync   = (phase_ff == PH_RUN) && (link_ff == LNK_ASYNC);
  assign isClk     = (phase_ff == PH_RUN) &&
                     ((link_ff == LNK_CLK) || (link_ff == LNK_CLK_HS));
  assign unusedHs  = handshakeIn;

  // entry, pulse counting and mode latch
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_ff    <= PH_STRAP;
      link_ff     <= LNK_NONE;
      strapCnt_ff <= 2'h0;
      pulseCnt_ff <= 4'h0;
      idleCnt_ff  <= '0;
    end
    else
    begin
      case (phase_ff)
        PH_STRAP:
        begin
          strapCnt_ff <= strapCnt_ff + 2'h1;
          if (strapCnt_ff == STRAP_WAIT)
          begin
            if (pin_ff[PIN_PULSE] && !pin_ff[PIN_SEL])
              phase_ff <= PH_COUNT;
            else
              phase_ff <= PH_OFF;
          end
        end
        PH_COUNT:
        begin
          if (pulseRise)
          begin
            idleCnt_ff <= '0;
            if (pulseCnt_ff != PULSE_SAT)
              pulseCnt_ff <= pulseCnt_ff + 4'h1;
          end
          else if (idleCnt_ff != SelIdleCyc[CNT_W-1:0])
            idleCnt_ff <= idleCnt_ff + 1'b1;
          if (serialStart ||
              (idleCnt_ff == SelIdleCyc[CNT_W-1:0]))
          begin
            phase_ff <= PH_RUN;
            if (pulseCnt_ff > PULSE_MAX)
              link_ff <= LNK_RESERVED;
            else if (pulseCnt_ff == CNT_ASYNC)
              link_ff <= LNK_ASYNC;
            else if (pulseCnt_ff == CNT_CLK)
              link_ff <= LNK_CLK;
            else if (pulseCnt_ff == CNT_CLK_HS)
              link_ff <= LNK_CLK_HS;
            else
              link_ff <= LNK_RESERVED;
          end
        end
        default:
          phase_ff <= phase_ff;
      endcase
    end
  end

  // async receiver with bit time learnt from first frame
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxState_ff <= RX_IDLE;
      bitCyc_ff  <= BitCycReset[CNT_W-1:0];
      rxCnt_ff   <= '0;
      rxBit_ff   <= 3'h0;
      rxSh_ff    <= 8'h00;
      calDone_ff <= 1'b0;
      rxPush_ff  <= 1'b0;
    end
    else
    begin
      rxPush_ff <= 1'b0;
      case (rxState_ff)
        RX_IDLE:
          // a fall that closes selection also starts the first frame
          if (rxFall && (isAsync || (phase_ff == PH_COUNT &&
                                     pulseCnt_ff == CNT_ASYNC)))
          begin
            rxState_ff <= RX_START;
            rxCnt_ff   <= calDone_ff ? (bitCyc_ff >> 1) : '0;
          end
        RX_START:
          if (!calDone_ff)
          begin
            rxCnt_ff <= rxCnt_ff + 1'b1;
            if (pin_ff[PIN_RX])
            begin
              if (rxCnt_ff < BIT_CYC_MIN[CNT_W-1:0])
                bitCyc_ff <= BIT_CYC_MIN[CNT_W-1:0];
              else
                bitCyc_ff <= rxCnt_ff;
              calDone_ff <= 1'b1;
              rxCnt_ff   <= rxCnt_ff >> 1;
              rxBit_ff   <= 3'h0;
              rxState_ff <= RX_DATA;
            end
          end
          else if (rxCnt_ff == '0)
          begin
            rxCnt_ff   <= bitCyc_ff - 1'b1;
            rxBit_ff   <= 3'h0;
            rxState_ff <= pin_ff[PIN_RX] ? RX_IDLE : RX_DATA;
          end
          else
            rxCnt_ff <= rxCnt_ff - 1'b1;
        RX_DATA:
          if (rxCnt_ff == '0)
          begin
            rxSh_ff  <= {pin_ff[PIN_RX], rxSh_ff[7:1]};
            rxCnt_ff <= bitCyc_ff - 1'b1;
            rxBit_ff <= rxBit_ff + 3'h1;
            if (rxBit_ff == LAST_BIT)
              rxState_ff <= RX_STOP;
          end
          else
            rxCnt_ff <= rxCnt_ff - 1'b1;
        RX_STOP:
          if (rxCnt_ff == '0)
          begin
            rxPush_ff  <= pin_ff[PIN_RX];
            rxState_ff <= RX_IDLE;
          end
          else
            rxCnt_ff <= rxCnt_ff - 1'b1;
        default:
          rxState_ff <= RX_IDLE;
      endcase
    end
  end

  // async transmitter, 10-bit frame shifted LSB first
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      txFrame_ff <= 10'h3FF;
      txLeft_ff  <= 4'h0;
      txCnt_ff   <= '0;
    end
    else if (txLeft_ff == 4'h0)
    begin
      if (isAsync && rspValid)
      begin
        txFrame_ff <= {1'b1, rspData, 1'b0};
        txLeft_ff  <= 4'hA;
        txCnt_ff   <= bitCyc_ff - 1'b1;
      end
    end
    else if (txCnt_ff == '0)
    begin
      txFrame_ff <= {1'b1, txFrame_ff[9:1]};
      txLeft_ff  <= txLeft_ff - 4'h1;
      txCnt_ff   <= bitCyc_ff - 1'b1;
    end
    else
      txCnt_ff <= txCnt_ff - 1'b1;
  end

  // clocked slave engine, MSB first
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      csiIn_ff    <= 8'h00;
      csiBit_ff   <= 3'h0;
      csiOut_ff   <= IDLE_BYTE;
      csiPush_ff  <= 1'b0;
      soBit_ff    <= 1'b1;
      holdData_ff <= 8'h00;
      held_ff     <= 1'b0;
    end
    else
    begin
      csiPush_ff <= 1'b0;
      if (isClk && sckRise)
      begin
        csiIn_ff  <= {csiIn_ff[6:0], pin_ff[PIN_SI]};
        csiBit_ff <= csiBit_ff + 3'h1;
        if (csiBit_ff == LAST_BIT)
        begin
          csiPush_ff <= 1'b1;
          csiOut_ff  <= held_ff ? holdData_ff : IDLE_BYTE;
        end
      end
      else if (isClk && sckFall)
      begin
        soBit_ff  <= csiOut_ff[7];
        csiOut_ff <= {csiOut_ff[6:0], 1'b1};
      end
      if (isClk && rspValid && !held_ff)
      begin
        holdData_ff <= rspData;
        held_ff     <= 1'b1;
      end
      else if (isClk && sckRise && csiBit_ff == LAST_BIT)
        held_ff <= 1'b0;
    end
  end

  // bytes that find the buffer full are dropped and flagged
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rxOverrun <= 1'b0;
    else if (pushValid && !bufReady)
      rxOverrun <= 1'b1;
  end

  assign pushValid = rxPush_ff || csiPush_ff;
  assign pushData  = rxPush_ff ? rxSh_ff[7:0] : csiIn_ff;

  plms_buffer2 #(
    .W (8)
  ) u_cmd_buf (
    .clk      (clk),
    .rstn     (rstn),
    .inValid  (pushValid),
    .inReady  (bufReady),
    .inData   (pushData),
    .outValid (cmdValid),
    .outReady (cmdReady),
    .outData  (cmdData)
  );

  assign rspReady = isAsync ? (txLeft_ff == 4'h0) : (isClk && !held_ff);
  assign asyncTransmitPin   = txFrame_ff[0];
  assign clockedSerialOut   = soBit_ff;
  assign clockedSerialOutOe = isClk;
  assign handshakeOe  = isClk && (link_ff == LNK_CLK_HS) && !unusedHs;
  assign handshakeOut = bufReady && !held_ff;
  assign progMode  = (phase_ff == PH_COUNT) || (phase_ff == PH_RUN);
  assign linkMode  = link_ff;
  assign linkValid = (phase_ff == PH_RUN);
endmodule

// >>> hdl/plms_pkg.sv
// constants and types of the programmer link mode selector
// assumes a 40 MHz core clock and an external programmer as link master
package plms_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned ASYNC_BPS_RESET = 9_600;
  localparam int unsigned ASYNC_BPS_MAX   = 153_600;
  localparam int unsigned SCK_HZ_MIN      = 2_400;
  localparam int unsigned SCK_HZ_MAX      = 2_500_000;
  // bit times in core cycles
  localparam int unsigned BIT_CYC_RESET = CLK_HZ / ASYNC_BPS_RESET;
  localparam int unsigned BIT_CYC_MIN   = CLK_HZ / ASYNC_BPS_MAX;
  // quiet time on the pulse pin that closes the selection phase
  localparam int unsigned SEL_IDLE_US  = 2_000;
  localparam int unsigned SEL_IDLE_CYC = SEL_IDLE_US * (CLK_HZ / 1_000_000);
  // widest counter, sized to hold the default quiet time
  localparam int unsigned CNT_W         = $clog2(SEL_IDLE_CYC + 1);
  // pulse counts, strap wait, idle byte and last bit index
  localparam logic [3:0] PULSE_MAX     = 4'hC;
  localparam logic [3:0] PULSE_SAT     = 4'hD;
  localparam logic [3:0] CNT_ASYNC     = 4'h0;
  localparam logic [3:0] CNT_CLK       = 4'h8;
  localparam logic [3:0] CNT_CLK_HS    = 4'hB;
  localparam logic [1:0] STRAP_WAIT    = 2'h3;
  localparam logic [7:0] IDLE_BYTE     = 8'hFF;
  localparam logic [2:0] LAST_BIT      = 3'h7;
  // synchronised pin vector positions
  localparam int unsigned PIN_PULSE = 0;
  localparam int unsigned PIN_SEL   = 1;
  localparam int unsigned PIN_RX    = 2;
  localparam int unsigned PIN_SCK   = 3;
  localparam int unsigned PIN_SI    = 4;
  localparam int unsigned PIN_N     = 5;

  typedef enum logic [2:0] {
    LNK_NONE, LNK_ASYNC, LNK_CLK, LNK_CLK_HS, LNK_RESERVED
  } plms_link_t;
  typedef enum logic [1:0] {
    PH_STRAP, PH_OFF, PH_COUNT, PH_RUN
  } plms_phase_t;
  typedef enum logic [1:0] {
    RX_IDLE, RX_START, RX_DATA, RX_STOP
  } plms_rx_t;
endpackage

// >>> hdl/plms_buffer2.sv
// two-entry word buffer with valid/ready on both sides
// assumes one clock domain, asynchronous active-low reset
`timescale 1ns/10ps
module plms_buffer2 #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // fill side
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // drain side
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  logic [W-1:0] mem_ff [2];
  logic         wrPtr_ff;
  logic         rdPtr_ff;
  logic [1:0]   count_ff;
  logic         push;
  logic         pop;

  assign inReady  = (count_ff != 2'h2);
  assign outValid = (count_ff != 2'h0);
  assign outData  = mem_ff[rdPtr_ff];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end
    else if (push)
      mem_ff[wrPtr_ff] <= inData;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_ff <= 1'b0;
      rdPtr_ff <= 1'b0;
      count_ff <= 2'h0;
    end
    else
    begin
      if (push)
        wrPtr_ff <= ~wrPtr_ff;
      if (pop)
        rdPtr_ff <= ~rdPtr_ff;
      if (push && !pop)
        count_ff <= count_ff + 2'h1;
      else if (pop && !push)
        count_ff <= count_ff - 2'h1;
    end
  end
endmodule

// >>> bench/plms_link_select_chk.sv
// port checker for the programmer link selector
// bound into every plms_link_select; sees its ports only
`timescale 1ns/10ps
module plms_link_select_chk
  import plms_pkg::*;
#(
  parameter int unsigned BitCycReset = BIT_CYC_RESET,
  parameter int unsigned SelIdleCyc  = SEL_IDLE_CYC
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // pins
  input wire logic       serialClockPin,
  input wire logic       handshakeIn,
  input wire logic       asyncTransmitPin,
  input wire logic       clockedSerialOut,
  input wire logic       clockedSerialOutOe,
  input wire logic       handshakeOe,
  // status and command side
  input wire logic       progMode,
  input wire plms_link_t linkMode,
  input wire logic       linkValid,
  input wire logic       cmdValid,
  input wire logic       cmdReady,
  input wire logic [7:0] cmdData
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic clkLink;
  assign clkLink = linkValid && (linkMode == LNK_CLK ||
                                 linkMode == LNK_CLK_HS);

  chk_mode_held: assert property (
    linkValid |=> linkValid && $stable(linkMode))
    else $error("link mode moved after latch");
  chk_hs_oe_only: assert property (
    handshakeOe |-> linkValid && linkMode == LNK_CLK_HS)
    else $error("handshake driven outside its mode");
  chk_hs_oe_on: assert property (
    linkValid && linkMode == LNK_CLK_HS && !handshakeIn |-> handshakeOe)
    else $error("handshake not driven in its mode");
  chk_so_oe_mode: assert property (
    clockedSerialOutOe == clkLink)
    else $error("serial out enable wrong for link");
  chk_tx_idle: assert property (
    !(linkValid && linkMode == LNK_ASYNC) |-> asyncTransmitPin)
    else $error("transmit pin active outside async link");
  chk_tx_start: assert property (
    $fell(asyncTransmitPin) |-> !asyncTransmitPin [*8])
    else $error("start bit too short");
  chk_entry_first: assert property (
    !progMode |-> !linkValid)
    else $error("link latched outside programming mode");
  chk_prog_stays: assert property (
    progMode |=> progMode)
    else $error("programming mode dropped");
  chk_cmd_hold: assert property (
    cmdValid && !cmdReady |=> cmdValid && $stable(cmdData))
    else $error("command byte lost while stalled");
  chk_reserved_idle: assert property (
    linkValid && linkMode == LNK_RESERVED |-> !cmdValid)
    else $error("reserved count delivered a byte");
  chk_so_on_fall: assert property (
    clkLink && $changed(clockedSerialOut) |-> !serialClockPin)
    else $error("serial out changed while clock high");

  cov_async: cover property (linkValid && linkMode == LNK_ASYNC);
  cov_hs: cover property (handshakeOe);
  cov_stall: cover property (cmdValid && !cmdReady ##1 cmdValid);
endmodule

bind plms_link_select plms_link_select_chk #(
  .BitCycReset(BitCycReset),
  .SelIdleCyc (SelIdleCyc)
) chk_i (
  .clk(clk), .rstn(rstn), .serialClockPin(serialClockPin),
  .handshakeIn(handshakeIn), .asyncTransmitPin(asyncTransmitPin),
  .clockedSerialOut(clockedSerialOut),
  .clockedSerialOutOe(clockedSerialOutOe), .handshakeOe(handshakeOe),
  .progMode(progMode), .linkMode(linkMode), .linkValid(linkValid),
  .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdData(cmdData)
);

// >>> bench/plms_prog_model.sv
// programmer model: strap, mode pulses, async and clocked bytes
// tasks are called from tb just after a clk rise, strap at times after a fall; pins move by NBA
`timescale 1ns/10ps
module plms_prog_model #(
  parameter int unsigned BitCyc  = 260,
  parameter int unsigned SckHalf = 4
) (
  // clock
  input wire logic clk,
  // pins toward the device
  output logic     modePulsePin,
  output logic     modeSelectPin,
  output logic     asyncReceivePin,
  output logic     serialClockPin,
  output logic     clockedSerialIn,
  // pin from the device
  input wire logic clockedSerialOut
);
  initial
  begin
    modePulsePin = 1'b0;
    modeSelectPin = 1'b0;
    asyncReceivePin = 1'b1;
    serialClockPin = 1'b1;
    clockedSerialIn = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic strap(input logic sel);
    modePulsePin <= 1'b1;
    modeSelectPin <= sel;
  endtask
  task automatic pulses(input int n);
    repeat (n)
    begin
      modePulsePin <= 1'b0;
      wt(4);
      modePulsePin <= 1'b1;
      wt(4);
    end
  endtask
  task automatic asyncSend(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      asyncReceivePin <= f[i];
      wt(BitCyc);
    end
  endtask
  // we make the clock, msb first, idle high
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      serialClockPin <= 1'b0;
      clockedSerialIn <= tx[i];
      wt(SckHalf);
      serialClockPin <= 1'b1;
      wt(SckHalf);
      rx[i] = clockedSerialOut;
    end
    // clock rests high between bytes
    wt(SckHalf);
  endtask
endmodule

// >>> bench/tb.sv
// testbench for the programmer link selector
// programmer model drives the link pins but handshakeIn; tb drives reset, handshakeIn and byte sides
`timescale 1ns/10ps
module tb;
  import plms_pkg::*;
  logic clk, rstn, cmdReady, rspValid, handshakeIn;
  logic [7:0] rspData, cmdData;
  logic mp, ms, rx, sck, si, tx, so, soOe, hsOut, hsOe;
  logic progMode, linkValid, rxOverrun, cmdValid, rspReady;
  plms_link_t linkMode;
  int failCount, nChecks;

  plms_prog_model plms_prog_model_i (.clk(clk), .modePulsePin(mp),
    .modeSelectPin(ms), .asyncReceivePin(rx), .serialClockPin(sck),
    .clockedSerialIn(si), .clockedSerialOut(so));
  plms_link_select #(.BitCycReset(260), .SelIdleCyc(200))
  plms_link_select_i (.clk(clk), .rstn(rstn), .modePulsePin(mp),
    .modeSelectPin(ms), .asyncReceivePin(rx), .asyncTransmitPin(tx),
    .serialClockPin(sck), .clockedSerialIn(si), .clockedSerialOut(so),
    .clockedSerialOutOe(soOe), .handshakeIn(handshakeIn),
    .handshakeOut(hsOut), .handshakeOe(hsOe), .progMode(progMode),
    .linkMode(linkMode), .linkValid(linkValid), .rxOverrun(rxOverrun),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdData(cmdData),
    .rspValid(rspValid), .rspReady(rspReady), .rspData(rspData));

  always #12.5 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      failCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic doReset(input logic sel, input int n);
    rstn <= 1'b0;
    plms_prog_model_i.strap(sel);
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    plms_prog_model_i.pulses(n);
  endtask
  task automatic waitLink();
    for (int i = 0; i < 400; i++)
    begin
      @(negedge clk);
      if (linkValid === 1'b1)
      begin
        @(posedge clk);
        return;
      end
    end
    failCount++;
    stop_test();
  endtask
  task automatic sendRsp(input logic [7:0] b);
    rspValid <= 1'b1;
    rspData <= b;
    for (int i = 0; i < 5000; i++)
    begin
      @(negedge clk);
      if (rspReady === 1'b1)
      begin
        @(posedge clk);
        rspValid <= 1'b0;
        return;
      end
    end
    failCount++;
    stop_test();
  endtask
  task automatic pop(input logic [7:0] e);
    @(negedge clk);
    chk({7'h0, cmdValid}, 8'h01);
    chk(cmdData, e);
    @(posedge clk);
    cmdReady <= 1'b1;
    @(posedge clk);
    cmdReady <= 1'b0;
  endtask
  task automatic s_async();
    logic [7:0] b;
    doReset(1'b0, 0);
    waitLink();
    chk({7'h0, progMode}, 8'h01);
    chk(8'(linkMode), 8'(LNK_ASYNC));
    plms_prog_model_i.asyncSend(8'hA5);
    pop(8'hA5);
    plms_prog_model_i.asyncSend(8'h3C);
    pop(8'h3C);
    sendRsp(8'h4B);
    for (int k = 0; k < 50 && tx !== 1'b0; k++)
      @(negedge clk);
    chk({7'h0, tx}, 8'h00);
    repeat (130) @(negedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (260) @(negedge clk);
      b[i] = tx;
    end
    chk(b, 8'h4B);
    repeat (260) @(negedge clk);
    chk({7'h0, tx}, 8'h01);
  endtask
  task automatic s_clk(input int n, input plms_link_t m);
    logic [7:0] r;
    doReset(1'b0, n);
    waitLink();
    chk(8'(linkMode), 8'(m));
    chk({7'h0, hsOe}, {7'h0, m == LNK_CLK_HS});
    chk({7'h0, soOe}, 8'h01);
    plms_prog_model_i.pulses(3);
    chk(8'(linkMode), 8'(m));
    sendRsp(8'hC3);
    plms_prog_model_i.xfer(8'h81, r);
    chk(r, IDLE_BYTE);
    plms_prog_model_i.xfer(8'h7E, r);
    chk(r, 8'hC3);
    if (m == LNK_CLK_HS)
      chk({7'h0, hsOut}, 8'h00);
    plms_prog_model_i.xfer(8'h55, r);
    chk({7'h0, rxOverrun}, 8'h01);
    pop(8'h81);
    pop(8'h7E);
    @(negedge clk);
    chk({7'h0, cmdValid}, 8'h00);
    if (m == LNK_CLK_HS)
      chk({7'h0, hsOut}, 8'h01);
  endtask
  task automatic s_reserved();
    int cnt [6] = '{1, 7, 9, 10, 12, 13};
    foreach (cnt[i])
    begin
      doReset(1'b0, cnt[i]);
      waitLink();
      chk(8'(linkMode), 8'(LNK_RESERVED));
    end
  endtask
  task automatic s_off();
    doReset(1'b1, 2);
    repeat (300) @(posedge clk);
    chk({6'h0, progMode, linkValid}, 8'h00);
  endtask

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    cmdReady = 1'b0;
    rspValid = 1'b0;
    rspData = 8'h00;
    handshakeIn = 1'b0;
    failCount = 0;
    nChecks = 0;
    @(posedge clk);
    s_async();
    s_clk(8, LNK_CLK);
    s_clk(11, LNK_CLK_HS);
    s_reserved();
    s_off();
    stop_test();
  end
endmodule
